/* File: verilog/eldio_pkg.sv */
package eldio_pkg;
	localparam logic [7:0]  ELDIO_LINE_OFS     = 8'h1c;
	localparam logic [7:0]  ELDIO_CTRL_OFS     = 8'h20;
	localparam int          ELDIO_PORT_A_LSB   = 0;
	localparam int          ELDIO_PORT_B_LSB   = 4;
	localparam int          ELDIO_A_EN_BIT     = 0;
	localparam int          ELDIO_B_EN_BIT     = 1;
	localparam logic [7:0]  ELDIO_PATTERN_RST  = 8'h00;
	localparam logic [1:0]  ELDIO_CTRL_RST     = 2'h0;
	localparam logic [31:0] ELDIO_RDATA_RST    = 32'h0000_0000;

	typedef enum logic [0:0]
	{
		ELDIO_IDLE   = 1'b0,
		ELDIO_ACCESS = 1'b1
	} eldio_bus_state_t;
endpackage

/* File: verilog/eldio_line_sync.sv */
module eldio_line_sync
	import eldio_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// lines in, sampled level out
	input  wire logic [7:0] line_in,
	output logic      [7:0] line_level
);
	logic [7:0] stage1_q;
	logic [7:0] stage2_q;
	logic [7:0] stage1_d;
	logic [7:0] stage2_d;

	always_comb
	begin
		stage1_d = line_in;
		stage2_d = stage1_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stage1_q <= 8'h00;
			stage2_q <= 8'h00;
		end
		else
		begin
			stage1_q <= stage1_d;
			stage2_q <= stage2_d;
		end
	end

	assign line_level = stage2_q;
endmodule

/* File: verilog/eldio_port.sv */
// What this block does
// - a read of the line register returns the level of all eight lines in bits 7..0.
// - bits 7..4 of the line read show port B lines 3..0, bit 4 being line 0.
// - bits 3..0 of the line read show port A lines 3..0, bit 0 being line 0.
// - the line state read and the output pattern write share one offset.
// - one output pattern serves both ports, low nibble A and next nibble B.
// - port B lines are driven from pattern bits 7..4 only while its enable is set.
// - port A lines are driven from pattern bits 3..0 only while its enable is set.
// - a disabled port leaves its lines undriven so the outside sets their level.
// - after reset both ports are inputs with drivers off.
module eldio_port
	import eldio_pkg::*;
(
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// port a lines
	input  wire logic [3:0]  port_a_line_i,
	output logic      [3:0]  port_a_line_o,
	output logic      [3:0]  port_a_line_oe_n,
	// port b lines
	input  wire logic [3:0]  port_b_line_i,
	output logic      [3:0]  port_b_line_o,
	output logic      [3:0]  port_b_line_oe_n
);
	eldio_bus_state_t state_q;
	eldio_bus_state_t state_d;
	logic [7:0]  pattern_q;
	logic [7:0]  pattern_d;
	logic [1:0]  ctrl_q;
	logic [1:0]  ctrl_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        ready_q;
	logic        ready_d;
	logic        err_q;
	logic        err_d;
	logic [3:0]  a_o_q;
	logic [3:0]  a_o_d;
	logic [3:0]  a_oen_q;
	logic [3:0]  a_oen_d;
	logic [3:0]  b_o_q;
	logic [3:0]  b_o_d;
	logic [3:0]  b_oen_q;
	logic [3:0]  b_oen_d;
	logic [7:0]  line_level;
	logic        hit_line;
	logic        hit_ctrl;

	// two flops, then the read data register, so a read shows the pins as they were three edges back
	eldio_line_sync u_sync
	(
		.pclk       (pclk),
		.presetn    (presetn),
		.line_in    ({port_b_line_i, port_a_line_i}),
		.line_level (line_level)
	);

	assign hit_line = (paddr == ELDIO_LINE_OFS);
	assign hit_ctrl = (paddr == ELDIO_CTRL_OFS);

	// bus handshake: no wait state, answer in access phase
	always_comb
	begin
		state_d   = state_q;
		pattern_d = pattern_q;
		ctrl_d    = ctrl_q;
		rdata_d   = rdata_q;
		ready_d   = 1'b0;
		err_d     = 1'b0;
		case (state_q)
			ELDIO_IDLE:
			begin
				if (psel && !penable)
				begin
					state_d = ELDIO_ACCESS;
					ready_d = 1'b1;
					err_d   = !(hit_line || hit_ctrl);
					rdata_d = ELDIO_RDATA_RST;
					if (!pwrite && hit_line)
						rdata_d[7:0] = line_level;
					else if (!pwrite && hit_ctrl)
						rdata_d[1:0] = ctrl_q;
				end
			end
			ELDIO_ACCESS:
			begin
				state_d = ELDIO_IDLE;
				if (psel && penable && pwrite && hit_line)
					pattern_d = pwdata[7:0];
				else if (psel && penable && pwrite && hit_ctrl)
					ctrl_d = pwdata[1:0];
			end
			default:
				state_d = ELDIO_IDLE;
		endcase
	end

	// pad drive from pattern and enables
	// registered from the next values, so the pins move on the write edge itself
	always_comb
	begin
		a_o_d   = pattern_d[ELDIO_PORT_A_LSB +: 4];
		b_o_d   = pattern_d[ELDIO_PORT_B_LSB +: 4];
		a_oen_d = {4{~ctrl_d[ELDIO_A_EN_BIT]}};
		b_oen_d = {4{~ctrl_d[ELDIO_B_EN_BIT]}};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q   <= ELDIO_IDLE;
			pattern_q <= ELDIO_PATTERN_RST;
			ctrl_q    <= ELDIO_CTRL_RST;
			rdata_q   <= ELDIO_RDATA_RST;
			ready_q   <= 1'b0;
			err_q     <= 1'b0;
			a_o_q     <= 4'h0;
			b_o_q     <= 4'h0;
			a_oen_q   <= 4'hf;
			b_oen_q   <= 4'hf;
		end
		else
		begin
			state_q   <= state_d;
			pattern_q <= pattern_d;
			ctrl_q    <= ctrl_d;
			rdata_q   <= rdata_d;
			ready_q   <= ready_d;
			err_q     <= err_d;
			a_o_q     <= a_o_d;
			b_o_q     <= b_o_d;
			a_oen_q   <= a_oen_d;
			b_oen_q   <= b_oen_d;
		end
	end

	assign prdata           = rdata_q;
	assign pready           = ready_q;
	assign pslverr          = err_q;
	assign port_a_line_o    = a_o_q;
	assign port_a_line_oe_n = a_oen_q;
	assign port_b_line_o    = b_o_q;
	assign port_b_line_oe_n = b_oen_q;

	// assertions
	line_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ELDIO_IDLE && psel && !penable && !pwrite && hit_line)
		|=> (prdata[7:0] == $past(line_level) && prdata[31:8] == 24'h0 && pready))
		else $error("line read data wrong");
	port_b_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ELDIO_IDLE && psel && !penable && !pwrite && hit_line
			&& $past(presetn) && $past(presetn, 2))
		|=> prdata[7:4] == $past(port_b_line_i, 3))
		else $error("port b read mapping wrong");
	port_a_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ELDIO_IDLE && psel && !penable && !pwrite && hit_line
			&& $past(presetn) && $past(presetn, 2))
		|=> prdata[3:0] == $past(port_a_line_i, 3))
		else $error("port a read mapping wrong");
	pattern_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ELDIO_ACCESS && psel && penable && pwrite && hit_line)
		|=> pattern_q == $past(pwdata[7:0]))
		else $error("pattern not loaded");
	pattern_split_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ELDIO_ACCESS && psel && penable && pwrite && hit_line)
		|=> (port_a_line_o == $past(pwdata[3:0]) && port_b_line_o == $past(pwdata[7:4])))
		else $error("pattern nibbles misrouted");
	bad_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ELDIO_ACCESS && psel && penable && pwrite && !hit_line)
		|=> pattern_q == $past(pattern_q))
		else $error("pattern changed by other offset");
	unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ELDIO_IDLE && psel && !penable && !hit_line && !hit_ctrl)
		|=> (pready && pslverr))
		else $error("unmapped access not refused");
	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held too long");
	ctrl_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ELDIO_IDLE && psel && !penable && !pwrite && hit_ctrl)
		|=> prdata == {30'h0, $past(ctrl_q)})
		else $error("enable read-back wrong");
	b_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_q[ELDIO_B_EN_BIT] ##1 !ctrl_q[ELDIO_B_EN_BIT] |-> port_b_line_oe_n == 4'hf)
		else $error("port b driven while disabled");
	a_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_q[ELDIO_A_EN_BIT] ##1 ctrl_q[ELDIO_A_EN_BIT] |-> port_a_line_oe_n == 4'h0)
		else $error("port a not driven while enabled");
	off_undriven_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(ctrl_q[ELDIO_A_EN_BIT]) |-> port_a_line_oe_n == 4'hf)
		else $error("port a still driven after disable");
	b_off_undriven_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(ctrl_q[ELDIO_B_EN_BIT]) |-> port_b_line_oe_n == 4'hf)
		else $error("port b still driven after disable");
	a_pattern_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_q[ELDIO_A_EN_BIT] |-> (port_a_line_oe_n == 4'h0 && port_a_line_o == pattern_q[3:0]))
		else $error("port a not driving its pattern");
	b_pattern_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_q[ELDIO_B_EN_BIT] |-> (port_b_line_oe_n == 4'h0 && port_b_line_o == pattern_q[7:4]))
		else $error("port b not driving its pattern");
	reset_output_a: assert property (@(posedge pclk)
		!presetn |-> (port_a_line_o == 4'h0 && port_b_line_o == 4'h0))
		else $error("drive values not cleared in reset");
	reset_input_a: assert property (@(posedge pclk)
		!presetn |-> (port_a_line_oe_n == 4'hf && port_b_line_oe_n == 4'hf))
		else $error("ports not input in reset");
	keep_pattern_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(ctrl_q[ELDIO_B_EN_BIT]) && $stable(pattern_q)
		|-> port_b_line_o == pattern_q[7:4])
		else $error("stored pattern lost on enable");

	read_cov: cover property (@(posedge pclk) disable iff (!presetn)
		pready && !pwrite && hit_line);
	write_cov: cover property (@(posedge pclk) disable iff (!presetn)
		pready && pwrite && hit_line);
	enable_cov: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(ctrl_q[ELDIO_A_EN_BIT]));
	err_cov: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
	both_cov: cover property (@(posedge pclk) disable iff (!presetn) ctrl_q == 2'h3);
endmodule

/* File: verif/eldio_line_model.sv */
module eldio_line_model (
	// design side
	input  wire logic [3:0] drv,
	input  wire logic [3:0] oe_n,
	// outside source
	input  wire logic [3:0] ext,
	output logic      [3:0] level
);
	timeunit 1ns;
	timeprecision 1ns;
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			level[i] = oe_n[i] ? ext[i] : drv[i];
	end
endmodule

/* File: verif/eldio_port_test.sv */
module eldio_port_test
	import eldio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 0;
	logic        presetn = 1'b1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  a_o, a_oe_n, a_i, b_o, b_oe_n, b_i;
	logic [7:0]  ext = 8'h3c;
	int          failures = 0;
	int          num_checks = 0;
	eldio_port i_eldio_port (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port_a_line_i(a_i), .port_a_line_o(a_o), .port_a_line_oe_n(a_oe_n),
		.port_b_line_i(b_i), .port_b_line_o(b_o), .port_b_line_oe_n(b_oe_n));
	eldio_line_model i_a (.drv(a_o), .oe_n(a_oe_n), .ext(ext[3:0]), .level(a_i));
	eldio_line_model i_b (.drv(b_o), .oe_n(b_oe_n), .ext(ext[7:4]), .level(b_i));
	always #50 pclk = ~pclk;
	task summarize;
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			failures++;
			summarize();
		end
	endtask
	// enable ports, then check drivers, the line read and the enable read-back
	task t_mode(input logic [1:0] en, input logic [7:0] lines, input logic [3:0] aoe,
		input logic [3:0] boe);
		logic [31:0] r;
		logic        e;
		apb(1'b1, ELDIO_CTRL_OFS, {30'h0, en}, r, e);
		repeat (4) @(posedge pclk);
		check("a_oe_n", {28'h0, aoe}, {28'h0, a_oe_n});
		check("b_oe_n", {28'h0, boe}, {28'h0, b_oe_n});
		apb(1'b0, ELDIO_LINE_OFS, 32'h0, r, e);
		check("lines", {24'h0, lines}, {24'h0, r[7:0]});
		check("line_err", 32'h0, {31'h0, e});
		apb(1'b0, ELDIO_CTRL_OFS, 32'h0, r, e);
		check("ctrl", {30'h0, en}, r);
	endtask
	// hold reset five edges, check the ports went to input, release
	task t_reset;
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		check("a_oe_n", 32'hf, {28'h0, a_oe_n});
		check("b_oe_n", 32'hf, {28'h0, b_oe_n});
		check("a_o", 32'h0, {28'h0, a_o});
		presetn <= 1'b1;
	endtask
	task t_pattern(input logic [7:0] p);
		logic [31:0] r;
		logic        e;
		apb(1'b1, ELDIO_LINE_OFS, {24'h0, p}, r, e);
		repeat (2) @(posedge pclk);
		check("a_o", {28'h0, p[3:0]}, {28'h0, a_o});
		check("b_o", {28'h0, p[7:4]}, {28'h0, b_o});
	endtask
	// unmapped read and write: refused, pattern p left on the pins
	task t_unmapped(input logic [7:0] p);
		logic [31:0] r;
		logic        e;
		apb(1'b0, 8'h40, 32'h0, r, e);
		check("pslverr", 32'h1, {31'h0, e});
		check("bad_rdata", 32'h0, r);
		apb(1'b1, 8'h40, 32'h0000_00ff, r, e);
		check("pslverr", 32'h1, {31'h0, e});
		repeat (2) @(posedge pclk);
		check("a_o", {28'h0, p[3:0]}, {28'h0, a_o});
		check("b_o", {28'h0, p[7:4]}, {28'h0, b_o});
	endtask
	initial
	begin
		t_reset();
		t_pattern(8'ha5);
		t_mode(2'h0, 8'h3c, 4'hf, 4'hf);
		t_mode(2'h1, 8'h35, 4'h0, 4'hf);
		t_mode(2'h2, 8'hac, 4'hf, 4'h0);
		t_mode(2'h0, 8'h3c, 4'hf, 4'hf);
		t_pattern(8'h96);
		t_mode(2'h3, 8'h96, 4'h0, 4'h0);
		t_unmapped(8'h96);
		t_reset();
		t_mode(2'h3, 8'h00, 4'h0, 4'h0);
		summarize();
	end
endmodule
